// ===== src/fault_pkg.sv
package fault_pkg;
   localparam int          NUM_SRC     = 7;
   localparam int          LOG_DEPTH   = 10;
   localparam int          CODE_W      = 4;
   // fault codes
   localparam logic [3:0]  CODE_NONE   = 4'h0;
   localparam logic [3:0]  CODE_OC     = 4'h1;
   localparam logic [3:0]  CODE_OH     = 4'h2;
   localparam logic [3:0]  CODE_OV     = 4'h3;
   localparam logic [3:0]  CODE_UV     = 4'h4;
   localparam logic [3:0]  CODE_SENS   = 4'h5;
   localparam logic [3:0]  CODE_OUT    = 4'h6;
   localparam logic [3:0]  CODE_OL     = 4'h7;
   // source bit positions
   localparam int          SRC_OC      = 0;
   localparam int          SRC_OUT     = 5;
   localparam int          SRC_OL      = 6;
   // which sources only a power cycle clears
   localparam logic [6:0]  HARD_MASK   = 7'h01;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_STATUS  = 8'h04;
   localparam logic [7:0]  OFS_CMD     = 8'h08;
   localparam logic [7:0]  OFS_OLTIME  = 8'h0c;
   localparam logic [7:0]  OFS_LOGCNT  = 8'h10;
   localparam logic [7:0]  OFS_LOG0    = 8'h20;
   // control bits
   localparam int          CTRL_BRAKE  = 0;
   localparam int          CTRL_3WIRE  = 1;
   localparam int          CTRL_TLOW   = 2;
   localparam int          CMD_CLR     = 0;
   localparam int          CMD_LOGCLR  = 1;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [15:0] OLTIME_RST  = 16'h0fa0;
   // blink half period: 0.25 s at 40 MHz
   localparam int          CLK_HZ      = 40_000_000;
   localparam int          BLINK_MS    = 250;
   localparam int          BLINK_CYC   = CLK_HZ / 1000 * BLINK_MS;

   typedef struct packed {
      logic forward_run_input;
      logic reverse_run_input;
      logic run_gate;
      logic run_hold;
      logic clear;
   } ctl_in_t;

   typedef struct packed {
      logic       healthy;
      logic       motor_stop;
      logic       brake_on;
      logic       fault_lamp;
      logic [3:0] panel_code;
   } ind_out_t;
endpackage : fault_pkg

// ===== src/motor_driver_fault_manager.sv
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
module motor_driver_fault_manager
   #(parameter int BLINK_CYCLES = fault_pkg::BLINK_CYC)
(
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // controller pins, asynchronous
   input  wire fault_pkg::ctl_in_t    ctl_pins,
   // detector levels: oc, oh, ov, uv, sens, out, overload
   input  wire logic [6:0]            det_pins,
   input  wire logic                  over_torque,
   // front panel
   input  wire logic                  panel_clear,
   input  wire logic                  panel_log_clear,
   // indications
   output fault_pkg::ind_out_t        ind
);
   import fault_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // three-stage pin synchronisers
   logic [12:0] s1_ff, s2_ff, s3_ff;
   logic [12:0] pins_ff;
   logic [12:0] raw;
   assign raw = {over_torque, det_pins, ctl_pins};

   // sampler chain
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end
      else
      begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // accept change when stages two and three agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pins_ff <= '0;
      else
         pins_ff <= (s2_ff & s3_ff) | (pins_ff & (s2_ff | s3_ff));
   end

   ctl_in_t    ctl;
   logic [6:0] det;
   logic       torque_hi;
   assign ctl       = pins_ff[4:0];
   assign det       = pins_ff[11:5];
   assign torque_hi = pins_ff[12];

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl_ff;
   logic [15:0] oltime_ff;
   logic        apb_wr, apb_rd;
   logic        sw_clear, sw_log_clear;
   assign apb_wr       = psel && penable && pwrite;
   assign apb_rd       = psel && penable && !pwrite;
   assign pready       = 1'b1;
   assign sw_clear     = apb_wr && paddr == OFS_CMD && pwdata[CMD_CLR];
   assign sw_log_clear = apb_wr && paddr == OFS_CMD && pwdata[CMD_LOGCLR];

   // writable config
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_ff   <= CTRL_RST;
         oltime_ff <= OLTIME_RST;
      end
      else if (apb_wr)
      begin
         if (paddr == OFS_CTRL)
            ctrl_ff <= pwdata & 32'h0000_0007;
         else if (paddr == OFS_OLTIME)
            oltime_ff <= pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // overload timer, faster when torque is far above rated
   logic [15:0] ol_cnt_ff;
   logic        ol_trip;
   logic        ol_heavy;
   assign ol_heavy = det[SRC_OL] && torque_hi;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ol_cnt_ff <= '0;
      else if (!det[SRC_OL])
         ol_cnt_ff <= '0;
      else if (!ol_trip)
         ol_cnt_ff <= ol_cnt_ff + (ol_heavy ? 16'h0002 : 16'h0001);
   end
   assign ol_trip = det[SRC_OL] && ol_cnt_ff >= oltime_ff;

   ////////////////////////////////////////////////////////////////////////
   // raw fault events
   logic [6:0] hit;
   always_comb
   begin
      hit          = det;
      hit[SRC_OUT] = det[SRC_OUT] && !ctrl_ff[CTRL_TLOW];
      hit[SRC_OL]  = ol_trip;
   end

   ////////////////////////////////////////////////////////////////////////
   // clear qualification
   logic clr_prev_ff;
   logic pin_clr_ok;
   logic any_clear;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clr_prev_ff <= 1'b0;
      else
         clr_prev_ff <= ctl.clear;
   end

   // edge only, gated by run inputs
   assign pin_clr_ok = ctl.clear && !clr_prev_ff
                     && !ctl.forward_run_input && !ctl.reverse_run_input
                     && !(ctrl_ff[CTRL_3WIRE] && ctl.run_gate && ctl.run_hold);
   assign any_clear  = pin_clr_ok || panel_clear || sw_clear;

   ////////////////////////////////////////////////////////////////////////
   // latched fault; new events win over clear
   logic [6:0] latch_ff;
   logic [3:0] code_ff;
   logic       active;
   assign active = |latch_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         latch_ff <= '0;
      else if (any_clear)
         latch_ff <= (latch_ff & HARD_MASK) | hit;
      else
         latch_ff <= latch_ff | hit;
   end

   function automatic logic [3:0] code_of(input logic [6:0] v);
      logic [3:0] c;
      c = CODE_NONE;
      for (int i = NUM_SRC - 1; i >= 0; i--)
         if (v[i])
            c = 4'(i + 1);
      return c;
   endfunction : code_of

   // new fault events for logging
   logic [6:0] new_hit;
   assign new_hit = hit & ~latch_ff;

   // code shown on the panel
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         code_ff <= CODE_NONE;
      else if (|new_hit)
         code_ff <= code_of(new_hit);
      else if (!active)
         code_ff <= CODE_NONE;
   end

   ////////////////////////////////////////////////////////////////////////
   // lamp blink
   logic [31:0] blink_cnt_ff;
   logic        blink_ff;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blink_cnt_ff <= '0;
         blink_ff     <= 1'b0;
      end
      else if (!active)
      begin
         blink_cnt_ff <= '0;
         blink_ff     <= 1'b0;
      end
      else if (blink_cnt_ff >= 32'(BLINK_CYCLES - 1))
      begin
         blink_cnt_ff <= '0;
         blink_ff     <= !blink_ff;
      end
      else
         blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
   end

   ////////////////////////////////////////////////////////////////////////
   // indications, registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ind <= '{healthy: 1'b0, motor_stop: 1'b1, brake_on: 1'b1,
                  fault_lamp: 1'b0, panel_code: CODE_NONE};
      else
      begin
         ind.healthy    <= !active && !(|hit);
         ind.motor_stop <= active || (|hit);
         ind.brake_on   <= (active || (|hit)) && !ctrl_ff[CTRL_BRAKE];
         ind.fault_lamp <= active && blink_ff;
         ind.panel_code <= active ? code_ff : CODE_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fault log, newest at index 0; held in the retained store
   logic [3:0] log_ff [LOG_DEPTH];
   logic [3:0] log_cnt_ff;
   logic       log_clr;
   assign log_clr = sw_log_clear || panel_log_clear;

   always_ff @(posedge pclk)
   begin
      if (|new_hit)
      begin
         log_ff[0] <= code_of(new_hit);
         for (int i = 1; i < LOG_DEPTH; i++)
            log_ff[i] <= log_ff[i-1];
      end
   end

   // count of valid entries, retained like the entries; new entry wins over clear
   always_ff @(posedge pclk)
   begin
      if (|new_hit)
         log_cnt_ff <= log_clr ? 4'h1 :
                       (log_cnt_ff == 4'(LOG_DEPTH)) ? log_cnt_ff : log_cnt_ff + 4'h1;
      else if (log_clr)
         log_cnt_ff <= '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // read decode
   logic [7:0] log_idx;
   assign log_idx = (paddr - OFS_LOG0) >> 2;
   always_comb
   begin
      prdata  = '0;
      pslverr = 1'b0;
      if (paddr == OFS_CTRL)
         prdata = ctrl_ff;
      else if (paddr == OFS_STATUS)
         prdata = {21'h0, code_ff, latch_ff};
      else if (paddr == OFS_CMD)
         prdata = '0;
      else if (paddr == OFS_OLTIME)
         prdata = {16'h0, oltime_ff};
      else if (paddr == OFS_LOGCNT)
         prdata = {28'h0, log_cnt_ff};
      else if (paddr >= OFS_LOG0 && log_idx < 8'(LOG_DEPTH) && paddr[1:0] == 2'b00)
         prdata = (log_idx < {4'h0, log_cnt_ff}) ? {28'h0, log_ff[log_idx[3:0]]} : '0;
      else
         pslverr = psel && penable;
   end
endmodule : motor_driver_fault_manager

// ===== tb/ctl_model.sv
`timescale 1ns/1ps
module ctl_model
(
   // clock
   input  wire logic         pclk,
   // controller levels
   output fault_pkg::ctl_in_t pins
);
   import fault_pkg::*;
   initial pins = '0;
   // run levels change after an edge
   task automatic run(input logic f, input logic r, input logic g, input logic h);
      @(posedge pclk);
      pins <= '{f, r, g, h, pins.clear};
   endtask : run
   // clear level only
   task automatic hold(input logic v);
      @(posedge pclk);
      pins.clear <= v;
   endtask : hold
   // off-to-on edge, held past the sync stages
   task automatic pulse();
      hold(1'b1);
      repeat (6) @(posedge pclk);
      hold(1'b0);
      repeat (6) @(posedge pclk);
   endtask : pulse
endmodule : ctl_model

// ===== tb/fault_chk.sv
`timescale 1ns/1ps
module fault_chk
   #(parameter int BLINK_CYCLES = 4)
(
   // bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pins
   input wire logic [6:0]  det_pins,
   input fault_pkg::ind_out_t ind
);
   import fault_pkg::*;
   logic       brk_rel_ff;
   logic [7:0] still_ff;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // track brake-release bit of the control word
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) brk_rel_ff <= 1'b0;
      else if (psel && penable && pwrite && paddr == OFS_CTRL) brk_rel_ff <= pwdata[0];
   // cycles the lamp sits still while faulted
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) still_ff <= 8'h00;
      else if (ind.healthy || $changed(ind.fault_lamp)) still_ff <= 8'h00;
      else still_ff <= still_ff + 8'h01;
   //////////////////////////////
   AST_STOP: assert property (ind.panel_code != CODE_NONE |-> !ind.healthy && ind.motor_stop)
      else $error("fault shown but not stopped");
   AST_IDLE: assert property (ind.healthy |-> ind.panel_code == CODE_NONE && !ind.fault_lamp)
      else $error("indication without fault");
   AST_BLINK: assert property (still_ff <= BLINK_CYCLES + 1)
      else $error("lamp not blinking");
   AST_BRAKE: assert property ($fell(ind.healthy) |-> ind.brake_on == !brk_rel_ff)
      else $error("brake action wrong");
   AST_HEAT: assert property ($rose(det_pins[1]) |-> ##[1:8] !ind.healthy)
      else $error("overheat not latched");
   AST_OC: assert property (ind.panel_code == CODE_OC |=> !ind.healthy)
      else $error("overcurrent cleared");
   AST_RDY: assert property (psel && penable |-> pready)
      else $error("no ready");
   AST_ERR: assert property (psel && penable && paddr == 8'hfc |-> pslverr)
      else $error("unmapped not refused");
   AST_OK: assert property (psel && penable && paddr == OFS_OLTIME |-> !pslverr)
      else $error("mapped refused");
endmodule : fault_chk
bind motor_driver_fault_manager fault_chk #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .det_pins(det_pins), .ind(ind));

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
   import fault_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, re, pready, pslverr;
   logic        over_torque, panel_clear, panel_log_clear;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rq;
   logic [6:0]  det;
   ctl_in_t     ctl;
   ind_out_t    ind;
   int          fails, checked;
   // 40 MHz
   always #12.5 pclk = ~pclk;
   motor_driver_fault_manager #(.BLINK_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl_pins(ctl), .det_pins(det),
      .over_torque(over_torque), .panel_clear(panel_clear),
      .panel_log_clear(panel_log_clear), .ind(ind));
   ctl_model u_ctl (.pclk(pclk), .pins(ctl));
   //////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rq, e);
   endtask : rd
   // raise a detector, then remove its cause
   task automatic fault(input int b);
      @(posedge pclk);
      det[b] <= 1'b1;
      repeat (8) @(posedge pclk);
      det[b] <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask : fault
   task automatic pan();
      @(posedge pclk);
      panel_clear <= 1'b1;
      @(posedge pclk);
      panel_clear <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask : pan
   // watchdog
   initial
   begin
      #500us;
      fails++;
      print_verdict();
   end
   // main sequence
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, det} = '0;
      {over_torque, panel_clear, panel_log_clear} = '0;
      fails = 0;
      checked = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(ind.healthy, 1'b1);
      rd(OFS_CTRL, CTRL_RST);
      rd(OFS_OLTIME, {16'h0000, OLTIME_RST});
      wr(OFS_CMD, 32'h2);
      rd(OFS_LOGCNT, 32'h0);
      apb(1'b0, 8'hfc, 32'h0);
      chk(re, 1'b1);
      wr(OFS_CTRL, 32'h2);
      for (int k = 1; k < 6; k++)
      begin
         fault(k);
         chk({ind.healthy, ind.motor_stop, ind.brake_on, ind.panel_code}, {3'b011, 4'(k + 1)});
         u_ctl.run(k % 3 == 0, k % 3 == 1, k % 3 == 2, k % 3 == 2);
         u_ctl.pulse();
         chk(ind.healthy, 1'b0);
         u_ctl.run(1'b0, 1'b0, 1'b0, 1'b0);
         case (k % 3)
            0: u_ctl.pulse();
            1: pan();
            default: wr(OFS_CMD, 32'h1);
         endcase
         repeat (4) @(posedge pclk);
         chk(ind.healthy, 1'b1);
      end
      rd(OFS_LOGCNT, 32'h5);
      rd(OFS_LOG0, CODE_OUT);
      rd(OFS_LOG0 + 8'h10, CODE_OH);
      rd(OFS_LOG0 + 8'h14, 32'h0);
      wr(OFS_CMD, 32'h2);
      rd(OFS_LOGCNT, 32'h0);
      u_ctl.hold(1'b1);
      fault(2);
      chk(ind.healthy, 1'b0);
      u_ctl.hold(1'b0);
      pan();
      wr(OFS_CTRL, 32'h5);
      fault(5);
      chk(ind.healthy, 1'b1);
      fault(1);
      chk({ind.healthy, ind.brake_on}, 2'b00);
      wr(OFS_CMD, 32'h1);
      wr(OFS_OLTIME, 32'd40);
      det[6] <= 1'b1;
      repeat (30) @(posedge pclk);
      chk(ind.healthy, 1'b1);
      det[6] <= 1'b0;
      repeat (4) @(posedge pclk);
      over_torque <= 1'b1;
      det[6] <= 1'b1;
      repeat (30) @(posedge pclk);
      chk(ind.panel_code, CODE_OL);
      {over_torque, det[6]} <= 2'b00;
      repeat (6) @(posedge pclk);
      panel_log_clear <= 1'b1;
      wr(OFS_CMD, 32'h1);
      panel_log_clear <= 1'b0;
      rd(OFS_LOGCNT, 32'h0);
      chk(ind.healthy, 1'b1);
      fault(0);
      u_ctl.pulse();
      pan();
      wr(OFS_CMD, 32'h1);
      chk({ind.healthy, ind.panel_code}, {1'b0, CODE_OC});
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(ind.healthy, 1'b1);
      rd(OFS_LOGCNT, 32'h1);
      rd(OFS_LOG0, CODE_OC);
      print_verdict();
   end
endmodule : tb
